// >>> rtl/rfc_params.svh
`ifndef RFC_PARAMS_SVH
`define RFC_PARAMS_SVH
// frequencies in 0.01 Hz units, 16 bits
`define RFC_FREQ_W          16
`define RFC_FREQ_MAX        16'h2EE0
`define RFC_WIDTH_MAX       16'h0BB8
`define RFC_RATIO_DECEL     8'h00
`define RFC_RATIO_CANCEL    8'hFF
`define RFC_RATIO_MIN       8'h14
`define RFC_RATIO_MAX       8'h78
`define RFC_RATIO_FULL      8'h64
`define RFC_SAVE_AUTO       1'b0
`define RFC_SAVE_KEY        1'b1
`define RFC_CLK_HZ          10000000
`define RFC_WINDOW_MS       400
`define RFC_SAMPLE_MS       10
`define RFC_WINDOW_CYC      ((`RFC_CLK_HZ / 1000) * `RFC_WINDOW_MS)
`define RFC_SAMPLE_CYC      ((`RFC_CLK_HZ / 1000) * `RFC_SAMPLE_MS)
`define RFC_SS_CODE0        4'h0
`endif

// >>> rtl/rfc_pkg.sv
package rfc_pkg;
   typedef struct packed {
      logic [15:0] center0;
      logic [15:0] center1;
      logic [15:0] center2;
      logic [15:0] width;
   } rfc_jump_t;
   typedef enum logic [1:0] {RFC_NORMAL, RFC_LOST} rfc_loss_t;
endpackage

// >>> rtl/rfc_reference_frequency_conditioner.sv
`timescale 1ns/1ps
`include "rfc_params.svh"
// Overview of operation
// [RQ1] auto mode saves keypad reference at power loss
// [RQ2] key mode saves only on save key
// [RQ3] command under tenth in window: fallback ratio
// [RQ4] above recovery threshold: follow command again
// [RQ5] ratio: decel, 20..120 percent, or cancel
// [RQ6] cancel: flag only, reference unchanged
// [RQ7] decel or cancel: threshold is 0.2 level
// [RQ8] ratio 100 or more: threshold is full level
// [RQ9] command level sampled at fixed intervals
// [RQ10] detection uses unfiltered analog input
// [RQ11] jump band holds bottom until top exceeded
// [RQ12] overlapping jump bands merge into one
// [RQ13] centre 0..120 Hz, zero means none
// [RQ14] width 0..30 Hz, zero disables all
// [RQ15] four selects form step index 1..15
// [RQ16] step frequencies 0..120 Hz
// [RQ17] steps only when selects assigned codes 0..3
// [RQ18] source avoids abrupt command steps
// [RQ19] loss flag held until recovery crossing
module rfc_reference_frequency_conditioner
   import rfc_pkg::*;
#(
   parameter int WINDOW_CYC = `RFC_WINDOW_CYC,
   parameter int SAMPLE_CYC = `RFC_SAMPLE_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // power and keypad
   input  wire logic        powerLoss,
   input  wire logic        saveKey,
   input  wire logic        refSaveMode,
   input  wire logic [15:0] keypadFreq,
   input  wire logic        keypadWrite,
   output logic      [15:0] keypadRef,
   output logic      [15:0] savedRef,
   // analog command
   input  wire logic        useAnalog,
   input  wire logic [15:0] analogRaw,
   input  wire logic [15:0] analogFilt,
   input  wire logic [7:0]  lossFallbackRatio,
   output logic             refLoss,
   // steps
   input  wire logic        stepSelWeightOne,
   input  wire logic        stepSelWeightTwo,
   input  wire logic        stepSelWeightFour,
   input  wire logic        stepSelWeightEight,
   input  wire logic [15:0] stepSelAssigned,
   input  wire logic [15*16-1:0] stepFreq,
   // jump settings
   input  wire rfc_jump_t   jumpCfg,
   // result
   output logic      [15:0] refOut
);
   // pins through three flops, change taken when last two agree
   logic [3:0] ssS1_q, ssS2_q, ssS3_q, ssStable_q, ssStable_d;
   logic [2:0] ctlS1_q, ctlS2_q, ctlS3_q, ctl_q, ctl_d;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ssS1_q  <= 4'h0;
         ssS2_q  <= 4'h0;
         ssS3_q  <= 4'h0;
         ctlS1_q <= 3'h0;
         ctlS2_q <= 3'h0;
         ctlS3_q <= 3'h0;
      end else begin
         ssS1_q  <= {stepSelWeightEight, stepSelWeightFour, stepSelWeightTwo, stepSelWeightOne};
         ssS2_q  <= ssS1_q;
         ssS3_q  <= ssS2_q;
         ctlS1_q <= {keypadWrite, saveKey, powerLoss};
         ctlS2_q <= ctlS1_q;
         ctlS3_q <= ctlS2_q;
      end
   end
   always_comb begin
      ssStable_d = (ssS2_q == ssS3_q) ? ssS3_q : ssStable_q;
      ctl_d      = (ctlS2_q == ctlS3_q) ? ctlS3_q : ctl_q;
   end
   // keypad reference and its non-volatile copy
   logic [15:0] keyRef_q, keyRef_d, save_q, save_d;
   logic        ctlPrev_q;
   logic        keyPrev_q;
   logic        powerUp_q;
   always_comb begin
      keyRef_d = keyRef_q;
      save_d   = save_q;
      if (powerUp_q)
         keyRef_d = save_q;                                   // see [RQ1] see [RQ2]
      else if (ctl_q[2])
         keyRef_d = (keypadFreq > `RFC_FREQ_MAX) ? `RFC_FREQ_MAX : keypadFreq;
      if (refSaveMode == `RFC_SAVE_AUTO && ctl_q[0] && !ctlPrev_q)
         save_d = keyRef_q;                                   // see [RQ1]
      if (refSaveMode == `RFC_SAVE_KEY && ctl_q[1] && !keyPrev_q)
         save_d = keyRef_q;                                   // see [RQ2]
   end
   // save store holds its value across arst_n; it models the retained memory
   always_ff @(posedge clk) begin
      save_q <= save_d;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ssStable_q <= 4'h0;
         ctl_q      <= 3'h0;
         keyRef_q   <= 16'h0000;
         ctlPrev_q  <= 1'b0;
         keyPrev_q  <= 1'b0;
         powerUp_q  <= 1'b1;
      end else begin
         ssStable_q <= ssStable_d;
         ctl_q      <= ctl_d;
         keyRef_q   <= keyRef_d;
         ctlPrev_q  <= ctl_q[0];
         keyPrev_q  <= ctl_q[1];
         powerUp_q  <= 1'b0;
      end
   end
   // step select: active only when all four select functions are assigned
   logic        stepOn;
   logic [15:0] baseRef;
   always_comb begin
      stepOn = (stepSelAssigned == 16'h3210);                // see [RQ17]
      if (stepOn && ssStable_q != 4'h0)                       // see [RQ15]
         baseRef = stepFreq[(ssStable_q - 4'h1) * 16 +: 16];
      else
         baseRef = useAnalog ? analogFilt : keyRef_q;
      if (baseRef > `RFC_FREQ_MAX)
         baseRef = `RFC_FREQ_MAX;                             // see [RQ16]
   end
   // loss detection on the raw input, sampled each interval
   logic [31:0] sampCnt_q, sampCnt_d;
   logic [31:0] winCnt_q, winCnt_d;
   logic [15:0] sampledCommandLevel_q, sampledCommandLevel_d;
   logic [15:0] winRef_q, winRef_d, hold_q, hold_d;
   rfc_loss_t   loss_q, loss_d;
   logic [15:0] thresh;
   always_comb begin
      sampCnt_d             = sampCnt_q + 32'd1;
      winCnt_d              = winCnt_q;
      sampledCommandLevel_d = sampledCommandLevel_q;
      winRef_d              = winRef_q;
      hold_d                = hold_q;
      loss_d                = loss_q;
      if (lossFallbackRatio == `RFC_RATIO_DECEL || lossFallbackRatio == `RFC_RATIO_CANCEL)
         thresh = 16'((32'(sampledCommandLevel_q) * 32'd2) / 32'd10); // see [RQ7]
      else if (lossFallbackRatio >= `RFC_RATIO_FULL)
         thresh = sampledCommandLevel_q;                      // see [RQ8]
      else
         thresh = 16'((32'(sampledCommandLevel_q) * 32'(lossFallbackRatio)) / 32'd100);
      if (sampCnt_q >= 32'(SAMPLE_CYC - 1)) begin            // see [RQ9]
         sampCnt_d = 32'd0;
         if (loss_q == RFC_NORMAL) begin
            sampledCommandLevel_d = analogRaw;                // see [RQ10]
            // window spans exactly WINDOW_CYC / SAMPLE_CYC samples, not one more
            if (winCnt_q >= 32'(WINDOW_CYC / SAMPLE_CYC - 1)) begin
               winCnt_d = 32'd0;
               winRef_d = analogRaw;
            end else begin
               winCnt_d = winCnt_q + 32'd1;
            end
            if (useAnalog && 32'(analogRaw) * 32'd10 < 32'(winRef_q)) begin
               loss_d                = RFC_LOST;              // see [RQ3] see [RQ19]
               hold_d                = winRef_q;
               sampledCommandLevel_d = winRef_q;
            end
         end else if (analogRaw > thresh || !useAnalog) begin
            loss_d   = RFC_NORMAL;                            // see [RQ4] see [RQ19]
            winCnt_d = 32'd0;
            winRef_d = analogRaw;
         end
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sampCnt_q             <= 32'd0;
         winCnt_q              <= 32'd0;
         sampledCommandLevel_q <= 16'h0000;
         winRef_q              <= 16'h0000;
         hold_q                <= 16'h0000;
         loss_q                <= RFC_NORMAL;
      end else begin
         sampCnt_q             <= sampCnt_d;
         winCnt_q              <= winCnt_d;
         sampledCommandLevel_q <= sampledCommandLevel_d;
         winRef_q              <= winRef_d;
         hold_q                <= hold_d;
         loss_q                <= loss_d;
      end
   end
   // fallback reference while lost
   logic [15:0] condRef;
   logic [7:0]  ratioClip;
   always_comb begin
      ratioClip = (lossFallbackRatio > `RFC_RATIO_MAX) ? `RFC_RATIO_MAX :
                  (lossFallbackRatio < `RFC_RATIO_MIN) ? `RFC_RATIO_MIN : lossFallbackRatio;
      condRef = baseRef;
      if (loss_q == RFC_LOST && useAnalog && !(stepOn && ssStable_q != 4'h0)) begin
         if (lossFallbackRatio == `RFC_RATIO_CANCEL)
            condRef = baseRef;                                // see [RQ6]
         else if (lossFallbackRatio == `RFC_RATIO_DECEL)
            condRef = 16'h0000;                               // see [RQ5]
         else
            condRef = 16'((32'(hold_q) * 32'(ratioClip)) / 32'd100); // see [RQ5]
      end
   end
   // jump bands: merge overlaps, then hysteresis hold at the edge
   logic [15:0] lo [3];
   logic [15:0] hi [3];
   logic [15:0] mLo, mHi, jumpOut;
   logic [15:0] wClip;
   logic [15:0] out_q, out_d;
   logic [15:0] cen [3];
   assign cen[0] = jumpCfg.center0;
   assign cen[1] = jumpCfg.center1;
   assign cen[2] = jumpCfg.center2;
   always_comb begin
      wClip = (jumpCfg.width > `RFC_WIDTH_MAX) ? `RFC_WIDTH_MAX : jumpCfg.width;
      for (int i = 0; i < 3; i++) begin
         lo[i] = (cen[i] > (wClip >> 1)) ? cen[i] - (wClip >> 1) : 16'h0000;
         hi[i] = cen[i] + (wClip >> 1);
      end
      jumpOut = condRef;
      for (int i = 0; i < 3; i++) begin
         if (cen[i] != 16'h0000 && cen[i] <= `RFC_FREQ_MAX
             && wClip != 16'h0000) begin                     // see [RQ13] see [RQ14]
            mLo = lo[i];
            mHi = hi[i];
            for (int j = 0; j < 3; j++) begin
               if (cen[j] != 16'h0000 && lo[j] <= mHi && hi[j] >= mLo) begin // see [RQ12]
                  mLo = (lo[j] < mLo) ? lo[j] : mLo;
                  mHi = (hi[j] > mHi) ? hi[j] : mHi;
               end
            end
            if (condRef > mLo && condRef < mHi)
               jumpOut = (out_q >= mHi) ? mHi : mLo;          // see [RQ11]
         end else begin
            mLo = 16'h0000;
            mHi = 16'h0000;
         end
      end
      out_d = jumpOut;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         out_q <= 16'h0000;
      else
         out_q <= out_d;
   end
   // registered outputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         refOut    <= 16'h0000;
         refLoss   <= 1'b0;
         keypadRef <= 16'h0000;
         savedRef  <= 16'h0000;
      end else begin
         refOut    <= out_d;
         refLoss   <= (loss_d == RFC_LOST);                  // see [RQ19]
         keypadRef <= keyRef_d;
         savedRef  <= save_d;
      end
   end

   // loss flag may only fall on a sample point
   property p_lossHold;
      @(posedge clk) disable iff (!arst_n)
         (loss_q == RFC_LOST && sampCnt_q != 32'(SAMPLE_CYC - 1)) |=> refLoss;
   endproperty
   a_lossHold: assert property (p_lossHold) // see [RQ19]
      else $error("loss flag dropped between samples");

   property p_lossEntry;
      @(posedge clk) disable iff (!arst_n)
         (loss_q == RFC_NORMAL && loss_d == RFC_LOST)
         |-> (useAnalog && analogRaw < winRef_q);
   endproperty
   a_lossEntry: assert property (p_lossEntry) // see [RQ3]
      else $error("loss entered without a command drop");

   property p_recover;
      @(posedge clk) disable iff (!arst_n)
         (loss_q == RFC_LOST && loss_d == RFC_NORMAL)
         |-> (analogRaw > thresh || !useAnalog);
   endproperty
   a_recover: assert property (p_recover) // see [RQ4]
      else $error("loss left below the recovery level");

   property p_cancelKeeps;
      @(posedge clk) disable iff (!arst_n)
         (loss_q == RFC_LOST && lossFallbackRatio == `RFC_RATIO_CANCEL)
         |-> (condRef == baseRef);
   endproperty
   a_cancelKeeps: assert property (p_cancelKeeps) // see [RQ6]
      else $error("cancel setting changed the reference");

   property p_decelStop;
      @(posedge clk) disable iff (!arst_n)
         (loss_q == RFC_LOST && useAnalog && ssStable_q == 4'h0
          && lossFallbackRatio == `RFC_RATIO_DECEL) |-> (condRef == 16'h0000);
   endproperty
   a_decelStop: assert property (p_decelStop) // see [RQ5]
      else $error("decel setting did not ask for zero");

   // without assigned selects the keypad value must pass untouched
   property p_plainKeypad;
      @(posedge clk) disable iff (!arst_n)
         (!stepOn && !useAnalog) |-> (baseRef == keyRef_q);
   endproperty
   a_plainKeypad: assert property (p_plainKeypad) // see [RQ17]
      else $error("step used while selects unassigned");

   property p_zeroWidth;
      @(posedge clk) disable iff (!arst_n)
         (useAnalog && jumpCfg.width == 16'h0000) |=> (refOut == $past(condRef));
   endproperty
   a_zeroWidth: assert property (p_zeroWidth) // see [RQ14]
      else $error("jump applied with zero width");
   c_loss: cover property (@(posedge clk) disable iff (!arst_n) $rose(refLoss));
   c_recover: cover property (@(posedge clk) disable iff (!arst_n) $fell(refLoss));
   c_step: cover property (@(posedge clk) disable iff (!arst_n) stepOn && ssStable_q == 4'hF);
endmodule

// >>> sim/rfc_cmd_model.sv
`timescale 1ns/1ps
module rfc_cmd_model (
   // clock
   input  wire logic        clk,
   // control from the bench
   input  wire logic [15:0] target,
   input  wire logic        cut,
   // analog command pin
   output logic      [15:0] analogRaw
);
   logic [15:0] level = 16'h0000;
   assign analogRaw = level;
   // rises in small steps; drops at once to a lower target, or to zero on a commanded cut
   // moves on the rising edge so bench controls set at the falling edge are settled
   always @(posedge clk) begin
      if (cut)
         level <= 16'h0000;
      else if (level + 16'h0064 < target)
         level <= level + 16'h0064;
      else
         level <= target;
   end
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import rfc_pkg::*;
   typedef struct {logic [3:0] idx; logic [15:0] exp;} rfc_row_t;
   typedef struct {logic [7:0] ratio; logic [15:0] exp; logic [15:0] low;} rfc_loss_row_t;
   logic            clk = 1'b0;
   logic            arst_n = 1'b0;
   logic            powerLoss = 1'b0;
   logic            saveKey = 1'b0;
   logic            refSaveMode = 1'b0;
   logic            keypadWrite = 1'b0;
   logic            useAnalog = 1'b0;
   logic            cut = 1'b0;
   logic [15:0]     keypadFreq = 16'h0000;
   logic [15:0]     analogFilt = 16'h0000;
   logic [15:0]     target = 16'h0000;
   logic [15:0]     stepSelAssigned = 16'h3210;
   logic [7:0]      lossFallbackRatio = 8'h00;
   logic [3:0]      stepIdx = 4'h0;
   logic [239:0]    stepFreq = '0;
   rfc_jump_t       jumpCfg = '0;
   logic [15:0]     keypadRef, savedRef, refOut, analogRaw;
   logic            refLoss;
   int              errors = 0;
   int              compares = 0;
   int              n;
   rfc_row_t        rows [6];
   rfc_loss_row_t   lrows [4];
   always #50 clk = ~clk;
   rfc_cmd_model rfc_cmd_model_inst (.clk(clk), .target(target), .cut(cut), .analogRaw(analogRaw));
   rfc_reference_frequency_conditioner #(.WINDOW_CYC(400), .SAMPLE_CYC(10))
   rfc_reference_frequency_conditioner_inst (
      .clk(clk), .arst_n(arst_n), .powerLoss(powerLoss), .saveKey(saveKey),
      .refSaveMode(refSaveMode), .keypadFreq(keypadFreq), .keypadWrite(keypadWrite),
      .keypadRef(keypadRef), .savedRef(savedRef), .useAnalog(useAnalog),
      .analogRaw(analogRaw), .analogFilt(analogFilt), .lossFallbackRatio(lossFallbackRatio),
      .refLoss(refLoss), .stepSelWeightOne(stepIdx[0]), .stepSelWeightTwo(stepIdx[1]),
      .stepSelWeightFour(stepIdx[2]), .stepSelWeightEight(stepIdx[3]),
      .stepSelAssigned(stepSelAssigned), .stepFreq(stepFreq), .jumpCfg(jumpCfg),
      .refOut(refOut));
   task automatic give_verdict;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic settle;
      repeat (8) @(negedge clk);
   endtask
   task automatic setk(input logic [15:0] v);
      keypadFreq = v;
      keypadWrite = 1'b1;
      settle();
      keypadWrite = 1'b0;
      settle();
   endtask
   // bounded wait for the loss flag to reach a level
   task automatic waitloss(input logic want, input int lim);
      int i;
      for (i = 0; i < lim && refLoss !== want; i++)
         @(negedge clk);
   endtask
   task automatic rst;
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      settle();
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      give_verdict();
   end
   initial begin
      for (n = 1; n < 16; n++)
         stepFreq[(n-1)*16 +: 16] = 16'(n) * 16'h0200;
      rows = '{'{4'h0, 16'h0BB8}, '{4'h1, 16'h0200}, '{4'h2, 16'h0400},
               '{4'h4, 16'h0800}, '{4'h8, 16'h1000}, '{4'hF, 16'h1E00}};
      lrows = '{'{8'h32, 16'h0BB8, 16'h07D0}, '{8'h00, 16'h0000, 16'h0320},
                '{8'hFF, 16'h1770, 16'h0320}, '{8'h78, 16'h1C20, 16'h0FA0}};
      repeat (6) @(negedge clk);
      check(refOut, 16'h0000);
      check({15'h0, refLoss}, 16'h0000);
      arst_n = 1'b1;
      settle();
      setk(16'h0BB8);
      foreach (rows[i]) begin
         stepIdx = rows[i].idx;
         settle();
         check(refOut, rows[i].exp);
      end
      stepSelAssigned = 16'h0000;
      settle();
      check(refOut, 16'h0BB8);
      stepSelAssigned = 16'h3210;
      stepFreq[224 +: 16] = 16'hFFFF;
      settle();
      check(refOut, 16'h2EE0);
      stepIdx = 4'h0;
      jumpCfg = '{16'h0000, 16'h0000, 16'h0000, 16'h03E8};
      setk(16'h0190);
      check(refOut, 16'h0190);
      jumpCfg = '{16'h1388, 16'h15E0, 16'h0000, 16'h0000};
      setk(16'h1388);
      check(refOut, 16'h1388);
      jumpCfg.width = 16'h03E8;
      setk(16'h0BB8);
      setk(16'h170C);
      check(refOut, 16'h1194);
      setk(16'h1B58);
      check(refOut, 16'h1B58);
      setk(16'h1388);
      check(refOut, 16'h17D4);
      jumpCfg = '0;
      useAnalog = 1'b1;
      analogFilt = 16'h1770;
      foreach (lrows[i]) begin
         lossFallbackRatio = lrows[i].ratio;
         target = 16'h1770;
         repeat (600) @(negedge clk);
         check({15'h0, refLoss}, 16'h0000);
         cut = 1'b1;
         waitloss(1'b1, 1000);
         cut = 1'b0;
         target = lrows[i].low;
         check({15'h0, refLoss}, 16'h0001);
         settle();
         check(refOut, lrows[i].exp);
         repeat (300) @(negedge clk);
         check({15'h0, refLoss}, 16'h0001);
         target = 16'h1900;
         waitloss(1'b0, 1000);
         check({15'h0, refLoss}, 16'h0000);
      end
      useAnalog = 1'b0;
      setk(16'h04D2);
      powerLoss = 1'b1;
      settle();
      powerLoss = 1'b0;
      rst();
      check(keypadRef, 16'h04D2);
      refSaveMode = 1'b1;
      setk(16'h07D0);
      saveKey = 1'b1;
      settle();
      saveKey = 1'b0;
      setk(16'h0BB8);
      powerLoss = 1'b1;
      settle();
      powerLoss = 1'b0;
      rst();
      check(keypadRef, 16'h07D0);
      check(savedRef, 16'h07D0);
      give_verdict();
   end
endmodule
